// ==== rtl/kii_defs.vh ====
// Purpose: Constants for the keyboard input interrupt block.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses; 8-bit registers sit in bits 7:0.
`ifndef KII_DEFS_VH
`define KII_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define KII_OFS_STATUS_CONTROL 12'h000
`define KII_OFS_PIN_ENABLE 12'h004
`define KII_OFS_EVT_STATUS 12'h008
`define KII_OFS_EVT_MASK 12'h00C
`define KII_OFS_LINE_STATE 12'h010

// ----------------------------------------------------------------
// Status/control field positions
// ----------------------------------------------------------------
`define KII_BIT_MODE 0
`define KII_BIT_IRQ_EN 1
`define KII_BIT_ACK 2
`define KII_BIT_FLAG 3
`define KII_POL_LSB 4
`define KII_POL_MSB 7

// ----------------------------------------------------------------
// Event status bit positions and width
// ----------------------------------------------------------------
`define KII_EVT_KEY 0
`define KII_EVT_WAKE 1
`define KII_EVT_BUSERR 2
`define KII_EVT_W 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define KII_RST_CTRL 8'h00
`define KII_RST_PIN_EN 8'h00
`define KII_RST_EVT 3'h0

`endif

// ==== rtl/kii_line_det.v ====
// Purpose: Per-line level and edge detection for the key inputs.
// Assumes: Inputs synchronous to pclk.
// Notes: Outputs are combinational from one sample flop per line.
`timescale 1ns/1ns

module kii_line_det #(
   parameter NUM_LINES = 8, // Number of key lines
   parameter POL_LINES = 4 // Upper lines with polarity choice
) (
   pclk,
   presetn,
   key_in,
   pol_sel,
   asserted,
   rise_asserted,
   was_asserted
);
   input wire pclk;
   input wire presetn;
   input wire [NUM_LINES-1:0] key_in;
   input wire [POL_LINES-1:0] pol_sel;
   output wire [NUM_LINES-1:0] asserted;
   output wire [NUM_LINES-1:0] rise_asserted;
   output wire [NUM_LINES-1:0] was_asserted;

   // ----------------------------------------------------------------
   // Asserted level per line
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
         if (gi >= NUM_LINES - POL_LINES) begin : g_pol
            // High or rising when select is one
            assign asserted[gi] = pol_sel[gi-(NUM_LINES-POL_LINES)] ?
               key_in[gi] : ~key_in[gi];
         end else begin : g_fix
            // Low or falling only
            assign asserted[gi] = ~key_in[gi];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Previous sample of asserted state
   // ----------------------------------------------------------------
   reg [NUM_LINES-1:0] prev_ff; // Asserted state last cycle

   // Starts as asserted so a held line gives no edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= {NUM_LINES{1'b1}};
      end else begin
         prev_ff <= asserted;
      end
   end

   // Edge only from the deasserted level
   assign rise_asserted = asserted & ~prev_ff;
   assign was_asserted = prev_ff;

endmodule // kii_line_det

// ==== rtl/kii_top.v ====
// Purpose: Keyboard input interrupt block with APB register access.
// Assumes: Key inputs synchronous to pclk; mode inputs from power logic.
// Notes: One wait state on every APB access; irq is a level.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "kii_defs.vh"

module kii_top #(
   parameter NUM_LINES = 8, // Key input lines
   parameter POL_LINES = 4, // Lines with selectable polarity
   parameter ADDR_W = 12 // APB address width
) (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   key_in,
   wait_mode,
   stop_mode,
   irq,
   wake_req
);
   input wire pclk; // Bus clock
   input wire presetn; // Async reset, active low
   input wire psel; // APB select
   input wire penable; // APB access phase
   input wire pwrite; // APB direction
   input wire [ADDR_W-1:0] paddr; // APB byte address
   input wire [31:0] pwdata; // APB write data
   output wire [31:0] prdata; // APB read data
   output wire pready; // APB ready
   output wire pslverr; // APB error
   input wire [NUM_LINES-1:0] key_in; // Key lines
   input wire wait_mode; // Processor in wait mode
   input wire stop_mode; // Processor in stop3 mode
   output wire irq; // Interrupt request level
   output wire wake_req; // Wake-up request level

   // ----------------------------------------------------------------
   // Address decode helper
   // ----------------------------------------------------------------
   // One-hot select of the register addressed
   function [4:0] reg_sel;
      input [ADDR_W-1:0] addr;
      begin
         reg_sel = 5'h00;
         case (addr[11:0])
            `KII_OFS_STATUS_CONTROL: reg_sel = 5'h01;
            `KII_OFS_PIN_ENABLE: reg_sel = 5'h02;
            `KII_OFS_EVT_STATUS: reg_sel = 5'h04;
            `KII_OFS_EVT_MASK: reg_sel = 5'h08;
            `KII_OFS_LINE_STATE: reg_sel = 5'h10;
            default: reg_sel = 5'h00;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [POL_LINES-1:0] line_polarity_select_ff; // Polarity per line
   reg key_event_flag_ff; // Shared event flag
   reg key_irq_enable_ff; // Interrupt enable
   reg detect_mode_select_ff; // 0 edge, 1 edge and level
   reg [NUM_LINES-1:0] line_trigger_enable_ff; // Pin enables
   reg [`KII_EVT_W-1:0] evt_status_ff; // Sticky events
   reg [`KII_EVT_W-1:0] evt_mask_ff; // Event mask
   reg [31:0] prdata_ff; // Read data
   reg pready_ff; // Ready
   reg pslverr_ff; // Error
   reg irq_ff; // Interrupt output
   reg wake_ff; // Wake output
   reg wake_prev_ff; // Wake last cycle, for event edge

   // Control register reset value, split into fields at reset
   localparam [7:0] RST_CTRL = `KII_RST_CTRL;

   // Next values
   reg [POL_LINES-1:0] nxt_line_polarity_select;
   reg nxt_key_event_flag;
   reg nxt_key_irq_enable;
   reg nxt_detect_mode_select;
   reg [NUM_LINES-1:0] nxt_line_trigger_enable;
   reg [`KII_EVT_W-1:0] nxt_evt_status;
   reg [`KII_EVT_W-1:0] nxt_evt_mask;
   reg [31:0] nxt_prdata;
   reg nxt_pready;
   reg nxt_pslverr;
   reg nxt_irq;
   reg nxt_wake;

   // ----------------------------------------------------------------
   // Bus phase decode
   // ----------------------------------------------------------------
   wire [4:0] sel; // Addressed register
   wire acc_first; // First access cycle, answer prepared
   wire acc_done; // Completing edge of a transfer
   wire wr_done; // Write takes effect
   wire unmapped; // No register at address

   assign sel = reg_sel(paddr);
   assign unmapped = (sel == 5'h00);
   assign acc_first = psel & penable & ~pready_ff;
   assign acc_done = psel & penable & pready_ff;
   // Commit only at the edge that ends the access, never on error
   assign wr_done = acc_done & pwrite & ~pslverr_ff;

   // ----------------------------------------------------------------
   // Line detection
   // ----------------------------------------------------------------
   wire [NUM_LINES-1:0] asserted; // Line at asserted level
   wire [NUM_LINES-1:0] rise_asserted; // Deasserted to asserted
   wire [NUM_LINES-1:0] was_asserted; // Asserted last cycle

   kii_line_det #(
      .NUM_LINES(NUM_LINES),
      .POL_LINES(POL_LINES)
   ) u_det (
      .pclk(pclk),
      .presetn(presetn),
      .key_in(key_in),
      .pol_sel(line_polarity_select_ff),
      .asserted(asserted),
      .rise_asserted(rise_asserted),
      .was_asserted(was_asserted)
   );

   // ----------------------------------------------------------------
   // Trigger logic
   // ----------------------------------------------------------------
   wire [NUM_LINES-1:0] en_rise; // Edges on enabled lines
   wire [NUM_LINES-1:0] en_held; // Enabled lines held asserted
   wire edge_evt; // Edge trigger this cycle
   wire level_hold; // Level keeps flag set
   wire ack_wr; // Acknowledge written

   // Changing polarity of an enabled line can look like an edge;
   // software should acknowledge after reconfiguring a line
   // Disabled lines produce nothing
   assign en_rise = rise_asserted & line_trigger_enable_ff;
   assign en_held = asserted & was_asserted & line_trigger_enable_ff;
   // In level mode other enabled lines must stay deasserted
   assign edge_evt = (|en_rise) &
      ~(detect_mode_select_ff & (|en_held));
   // Level mode keeps the flag while any enabled line asserted
   assign level_hold = detect_mode_select_ff &
      (|(asserted & line_trigger_enable_ff));
   assign ack_wr = wr_done & sel[0] & pwdata[`KII_BIT_ACK];

   // ----------------------------------------------------------------
   // Register next-state logic
   // ----------------------------------------------------------------
   // Writes, flag set and sticky events
   always @* begin
      nxt_line_polarity_select = line_polarity_select_ff;
      nxt_key_irq_enable = key_irq_enable_ff;
      nxt_detect_mode_select = detect_mode_select_ff;
      nxt_line_trigger_enable = line_trigger_enable_ff;
      nxt_evt_mask = evt_mask_ff;
      // Control writes
      if (wr_done && sel[0]) begin
         nxt_line_polarity_select =
            pwdata[`KII_POL_MSB:`KII_POL_LSB];
         nxt_key_irq_enable = pwdata[`KII_BIT_IRQ_EN];
         nxt_detect_mode_select = pwdata[`KII_BIT_MODE];
      end
      // Pin enable writes
      if (wr_done && sel[1]) begin
         nxt_line_trigger_enable = pwdata[NUM_LINES-1:0];
      end
      // Mask writes
      if (wr_done && sel[3]) begin
         nxt_evt_mask = pwdata[`KII_EVT_W-1:0];
      end
      // Flag: clear by acknowledge, set wins
      nxt_key_event_flag = key_event_flag_ff & ~ack_wr;
      if (edge_evt || level_hold) begin
         nxt_key_event_flag = 1'b1;
      end
      // Sticky events: write one clears, new event wins
      nxt_evt_status = evt_status_ff;
      if (wr_done && sel[2]) begin
         nxt_evt_status = evt_status_ff & ~pwdata[`KII_EVT_W-1:0];
      end
      if (edge_evt) begin
         nxt_evt_status[`KII_EVT_KEY] = 1'b1;
      end
      // Wake rise marks the event once per wake-up
      if (wake_ff && !wake_prev_ff) begin
         nxt_evt_status[`KII_EVT_WAKE] = 1'b1;
      end
      if (acc_first && unmapped) begin
         nxt_evt_status[`KII_EVT_BUSERR] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Bus answer logic
   // ----------------------------------------------------------------
   // One wait state, then ready with data or error
   always @* begin
      nxt_pready = acc_first;
      nxt_pslverr = acc_first & unmapped;
      nxt_prdata = 32'h00000000;
      if (acc_first && !pwrite) begin
         case (sel)
            5'h01: begin
               // Acknowledge bit always reads zero
               nxt_prdata[`KII_POL_MSB:`KII_POL_LSB] =
                  line_polarity_select_ff;
               nxt_prdata[`KII_BIT_FLAG] = key_event_flag_ff;
               nxt_prdata[`KII_BIT_IRQ_EN] = key_irq_enable_ff;
               nxt_prdata[`KII_BIT_MODE] =
                  detect_mode_select_ff;
            end
            5'h02: begin
               nxt_prdata[NUM_LINES-1:0] = line_trigger_enable_ff;
            end
            5'h04: begin
               nxt_prdata[`KII_EVT_W-1:0] = evt_status_ff;
            end
            5'h08: begin
               nxt_prdata[`KII_EVT_W-1:0] = evt_mask_ff;
            end
            5'h10: begin
               nxt_prdata[NUM_LINES-1:0] = key_in;
            end
            default: begin
               nxt_prdata = 32'h00000000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupt and wake logic
   // ----------------------------------------------------------------
   // Level request from flag and enable, or unmasked events
   always @* begin
      // Unmasked sticky events share the one request line
      nxt_irq = (key_event_flag_ff & key_irq_enable_ff) |
         (|(evt_status_ff & evt_mask_ff));
      nxt_wake = 1'b0;
      if (stop_mode) begin
         // Edge detector bypassed: asserted level wakes
         nxt_wake = |(asserted & line_trigger_enable_ff);
      end else if (wait_mode) begin
         nxt_wake = key_event_flag_ff;
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   // All controls and flag clear at reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Control fields take the register's reset value
         line_polarity_select_ff <=
            RST_CTRL[`KII_POL_MSB:`KII_POL_LSB];
         key_event_flag_ff <= RST_CTRL[`KII_BIT_FLAG];
         key_irq_enable_ff <= RST_CTRL[`KII_BIT_IRQ_EN];
         detect_mode_select_ff <= RST_CTRL[`KII_BIT_MODE];
         line_trigger_enable_ff <= `KII_RST_PIN_EN;
         evt_status_ff <= `KII_RST_EVT;
         evt_mask_ff <= `KII_RST_EVT;
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
         wake_prev_ff <= 1'b0;
      end else begin
         line_polarity_select_ff <= nxt_line_polarity_select;
         key_event_flag_ff <= nxt_key_event_flag;
         key_irq_enable_ff <= nxt_key_irq_enable;
         detect_mode_select_ff <= nxt_detect_mode_select;
         line_trigger_enable_ff <= nxt_line_trigger_enable;
         evt_status_ff <= nxt_evt_status;
         evt_mask_ff <= nxt_evt_mask;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         irq_ff <= nxt_irq;
         wake_ff <= nxt_wake;
         wake_prev_ff <= wake_ff;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign wake_req = wake_ff;

endmodule // kii_top

// ==== verif/kii_key_model.sv ====
// Purpose: Key switch model driving the key lines.
// Assumes: Bench sets the wanted line levels.
// Notes: Lines idle high, as with pull-ups.
`timescale 1ns/1ns
module kii_key_model #(
   parameter NUM_LINES = 8 // Key lines
) (
   input wire pclk,
   input wire [NUM_LINES-1:0] key_lvl,
   output logic [NUM_LINES-1:0] key_in
);
   // Pulled-up lines settle on the bus clock
   initial key_in = '1;
   always @(posedge pclk) begin
      key_in <= key_lvl;
   end
endmodule // kii_key_model

// ==== verif/kii_top_sva.sv ====
// Purpose: Port assertions for the key interrupt block.
// Assumes: One clock, async active-low reset.
// Notes: Bound to kii_top after the module.
`timescale 1ns/1ns
module kii_top_sva #(
   parameter NUM_LINES = 8,
   parameter ADDR_W = 12
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [NUM_LINES-1:0] key_in,
   input wire wait_mode,
   input wire stop_mode,
   input wire irq,
   input wire wake_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus access steps
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   sequence s_ctl_rd; pready && !pwrite && paddr == '0; endsequence
   property p_one_wait; s_access |=> s_answer; endproperty
   property p_idle; !(psel && penable) |=> !pready; endproperty
   property p_quiet; !pready |-> prdata == 32'h0; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   property p_ack_zero; s_ctl_rd |-> !prdata[2]; endproperty
   property p_irq; s_ctl_rd ##0 (prdata[3] && prdata[1]) |-> ##[0:1] irq;
   endproperty
   property p_no_wake; !stop_mode && !wait_mode |=> !wake_req; endproperty
   a_one_wait: assert property (p_one_wait) else $error("late ready");
   a_idle: assert property (p_idle) else $error("stray ready");
   a_quiet: assert property (p_quiet) else $error("read data off cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_upper: assert property (p_upper) else $error("upper bits set");
   a_ack_zero: assert property (p_ack_zero)
      else $error("ack read 1");
   a_irq: assert property (p_irq)
      else $error("no irq");
   a_no_wake: assert property (p_no_wake)
      else $error("wake idle");
endmodule // kii_top_sva
bind kii_top kii_top_sva #(.NUM_LINES(NUM_LINES), .ADDR_W(ADDR_W)) i_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .key_in(key_in),
   .wait_mode(wait_mode), .stop_mode(stop_mode), .irq(irq),
   .wake_req(wake_req));

// ==== verif/test_keyboard_input_interrupt.sv ====
// Purpose: Self-checking bench for the key interrupt block.
// Assumes: APB master tasks, key model on the lines.
// Notes: Rows hold {pin_en, ctrl, keys_before, keys_after, flag}.
`timescale 1ns/1ns
module test_keyboard_input_interrupt;
   logic pclk, presetn, psel, penable, pwrite, wait_mode, stop_mode, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [7:0] key_lvl;
   logic [35:0] r;
   wire [31:0] prdata;
   wire pready, pslverr, irq, wake_req;
   wire [7:0] key_in;
   int errors, checked, i;
   // Case table
   logic [35:0] rows [8] = '{36'h0100FFFE1, 36'h0100FEFF0, 36'h1010EFFF1,
      36'h1010FFEF0, 36'h1000FFEF1, 36'h0000FF000, 36'h80807FFF1,
      36'h0802FFF71};
   kii_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_in(key_in),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .irq(irq),
      .wake_req(wake_req));
   kii_key_model i_keys (.pclk(pclk), .key_lvl(key_lvl), .key_in(key_in));
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   task finish_test;
      $display("compares %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until ready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 0;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      // Flops update after this point, so pready is the sampled value
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) begin
         errors++;
         finish_test;
      end
      // Answer taken at the same edge that sees pready high
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      #200000 errors++;
      finish_test;
   end
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; wait_mode = 0; stop_mode = 0; key_lvl = 8'hFF;
      errors = 0; checked = 0;
      idle(6);
      presetn <= 1;
      apb(0, 12'h000, 0);
      chk(rd, 0);
      apb(0, 12'h004, 0);
      chk(rd, 0);
      for (i = 0; i < 8; i++) begin
         r = rows[i];
         apb(1, 12'h004, r[35:28]);
         apb(1, 12'h000, r[27:20]);
         key_lvl <= r[19:12];
         idle(3);
         apb(1, 12'h000, r[27:20] | 8'h04);
         apb(1, 12'h008, 32'h7);
         key_lvl <= r[11:4];
         idle(3);
         apb(0, 12'h000, 0);
         chk(rd[3], r[0]);
         @(negedge pclk);
         chk(irq, r[0] & r[21]);
      end
      $display("table rows done");
      // Level mode: ack cannot clear while held
      apb(1, 12'h004, 1);
      apb(1, 12'h000, 8'h01);
      key_lvl <= 8'hFE;
      idle(3);
      apb(1, 12'h000, 8'h05);
      apb(0, 12'h000, 0);
      chk(rd[3:0], 4'h9);
      stop_mode <= 1;
      idle(3);
      @(negedge pclk);
      chk(wake_req, 1);
      @(posedge pclk);
      key_lvl <= 8'hFF;
      stop_mode <= 0;
      wait_mode <= 1;
      idle(3);
      @(negedge pclk);
      chk(wake_req, 1);
      apb(1, 12'h000, 8'h05);
      apb(0, 12'h000, 0);
      chk(rd[3], 0);
      wait_mode <= 0;
      $display("level and wake done");
      // Level mode: new edge ignored while another line is held
      apb(1, 12'h004, 3);
      key_lvl <= 8'hFE;
      idle(3);
      apb(1, 12'h008, 32'h7);
      key_lvl <= 8'hFC;
      idle(3);
      apb(0, 12'h008, 0);
      chk(rd[0], 0);
      key_lvl <= 8'hFF;
      $display("held line done");
      // Masked event status drives irq, W1C clears
      apb(1, 12'h000, 0);
      apb(1, 12'h008, 32'h7);
      apb(1, 12'h00C, 1);
      @(negedge pclk);
      chk(irq, 0);
      @(posedge pclk);
      key_lvl <= 8'hFE;
      idle(3);
      @(negedge pclk);
      chk(irq, 1);
      apb(1, 12'h008, 1);
      apb(0, 12'h008, 0);
      chk(rd[0], 0);
      @(negedge pclk);
      chk(irq, 0);
      // Raw line state, then an unmapped address
      apb(0, 12'h010, 0);
      chk(rd, 32'hFE);
      apb(0, 12'h020, 0);
      chk(er, 1);
      chk(rd, 0);
      apb(0, 12'h008, 0);
      chk(rd[2], 1);
      $display("event and bus done");
      presetn <= 0;
      idle(2);
      presetn <= 1;
      apb(0, 12'h00C, 0);
      chk(rd, 0);
      apb(0, 12'h004, 0);
      chk(rd, 0);
      @(negedge pclk);
      chk(irq, 0);
      $display("event and reset done");
      finish_test;
   end
endmodule // test_keyboard_input_interrupt
